// ===== logic/ccpc_edge_prescale.sv
// Edge prescaler for capture events
`timescale 1ns/100ps
module ccpc_edge_prescale (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Control
   input wire logic clear,
   input wire logic edgeSeen,
   input wire logic [3:0] lastCount,
   // Event out
   output logic fire
);
   logic [3:0] edgeCount;
   logic [3:0] next_edgeCount;

   assign fire = edgeSeen && (edgeCount == lastCount);
   assign next_edgeCount = clear ? 4'h0 : (fire ? 4'h0 : edgeCount + 4'h1);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         edgeCount <= 4'h0;
      end else if (clear || edgeSeen) begin
         edgeCount <= next_edgeCount;
      end
   end

   chk_prescale_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
      (!clear && lastCount != 4'h0) |-> edgeCount <= lastCount) // R9
      else $error("Edge prescaler ran past its last count");
endmodule : ccpc_edge_prescale

// ===== logic/ccpc_pkg.sv
// Shared constants and types for the capture/compare/PWM control unit
// What this block does
// R1: PWM time base advances on system-clock-derived ticks, so PWM frequency follows the clock.
// R2: Any reset returns all unit registers to defaults and pins to input.
// R3: Control register bits 7-6 ignore writes and read back as zero.
// R4: In PWM, duty_low_bits at 5-4 are the two duty LSBs below duty_high_byte.
// R5: Mode field at bits 3-0 picks the mode; codes 11xx mean PWM.
// R6: Mode 0000 turns the unit off and clears its internal state.
// R7: Mode 0010 toggles the output pin on each compare match.
// R8: Modes 0100/0101 capture the timer on every falling/rising pin edge.
// R9: Modes 0110/0111 capture on every fourth/sixteenth rising edge.
// R10: Mode 1000 drives the pin high on match and sets match_event_flag.
// R11: Mode 1001 drives the pin low on match and sets match_event_flag.
// R12: Mode 1010 only sets the flag on match; pin unchanged.
// R13: Mode 1011 match sets unit10_event_flag and starts conversion if converter enabled.
// R14: Timer source register 0 holds four 2-bit fields, unit 4 at top.
// R15: Capture/compare uses first 16-bit timer when field LSB is 0, third otherwise.
// R16: A relocation bit moves the unit pin to an alternate pin; default after reset.
// R17: PWM period end clears timer, sets pin unless duty zero, latches duty byte.
// R18: PWM pin goes low when 10-bit time base equals latched duty.
// R19: In PWM the source field picks period timer 0, 1 or 2; code 11 reserved.
// R20: Reserved modes 0001 and 0011 keep the unit inactive, pin and flags unchanged; the code holds the pin level but drops its output enable (pinOe).
package ccpc_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [5:0] ADDR_UNIT_CONTROL = 6'h00;
   localparam logic [5:0] ADDR_TIMER_SOURCE = 6'h04;
   localparam logic [5:0] ADDR_DUTY_HIGH = 6'h08;
   localparam logic [5:0] ADDR_DUTY_SHADOW = 6'h0C;
   localparam logic [5:0] ADDR_CAPTURE = 6'h10;
   localparam logic [5:0] ADDR_COMPARE = 6'h14;
   localparam logic [5:0] ADDR_RELOCATE = 6'h18;
   localparam logic [5:0] ADDR_FLAGS = 6'h1C;
   localparam logic [5:0] ADDR_PERIOD = 6'h20;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] UNIT_CONTROL_RST = 8'h00;
   localparam logic [7:0] TIMER_SOURCE_RST = 8'h00;
   localparam logic [7:0] DUTY_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int UNIT2_SRC_LSB = 2;
   localparam int RELOCATE_BIT = 0;
   localparam int FLAG_MATCH_BIT = 0;
   localparam int FLAG_UNIT10_BIT = 1;
   // ----------------------------------------
   // Mode codes and counts
   // ----------------------------------------
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
   localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
   localparam logic [3:0] PRESCALE_LAST_1 = 4'h0;
   localparam logic [3:0] PRESCALE_LAST_4 = 4'h3;
   localparam logic [3:0] PRESCALE_LAST_16 = 4'hF;
   localparam logic [1:0] PWM_PHASE_LAST = 2'h3;
   localparam logic [1:0] SRC_RESERVED = 2'h3;

   typedef struct packed {
      logic [1:0] unused;
      logic [1:0] dutyLow;
      logic [3:0] mode;
   } ccpc_unit_control_s;

   typedef enum logic [2:0] {
      CLS_OFF,
      CLS_RESERVED,
      CLS_CAPTURE,
      CLS_COMPARE,
      CLS_PWM
   } ccpc_class_e;
endpackage : ccpc_pkg

// ===== logic/ccpc_unit.sv
// Capture/compare/PWM control unit with Avalon-MM register slave
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module ccpc_unit (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // Avalon-MM slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Timers
   input wire logic [15:0] timer1Count,
   input wire logic [15:0] timer3Count,
   input wire logic [2:0] periodTick,
   // Converter
   input wire logic adcEnable,
   output logic adcStart,
   // Status
   output logic matchEventFlag,
   output logic unit10EventFlag,
   // Pins, index 0 default, 1 alternate
   input wire logic [1:0] pinIn,
   output logic [1:0] pinOut,
   output logic [1:0] pinOe
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   ccpc_pkg::ccpc_unit_control_s unitControl;
   logic [7:0] timerSource;
   logic [7:0] dutyHigh;
   logic [7:0] dutyShadow;
   logic [1:0] dutyLatch;
   logic [15:0] captureValue;
   logic [15:0] compareValue;
   logic relocate;
   logic [7:0] periodLimit;
   logic [7:0] periodCount;
   logic [1:0] phase;
   logic outLevel;
   logic inPrev;
   logic matchPrev;
   logic next_level;
   ccpc_pkg::ccpc_class_e modeClass;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire logic wrAccept = avs_write && !avs_waitrequest;
   wire logic rdStart = avs_read && avs_waitrequest;
   wire logic wrCtrl = wrAccept && (avs_address == ccpc_pkg::ADDR_UNIT_CONTROL);
   wire logic wrSrc = wrAccept && (avs_address == ccpc_pkg::ADDR_TIMER_SOURCE);
   wire logic wrDuty = wrAccept && (avs_address == ccpc_pkg::ADDR_DUTY_HIGH);
   wire logic wrCmp = wrAccept && (avs_address == ccpc_pkg::ADDR_COMPARE);
   wire logic wrReloc = wrAccept && (avs_address == ccpc_pkg::ADDR_RELOCATE);
   wire logic wrFlags = wrAccept && (avs_address == ccpc_pkg::ADDR_FLAGS);
   wire logic wrPeriod = wrAccept && (avs_address == ccpc_pkg::ADDR_PERIOD);

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   wire logic [3:0] mode = unitControl.mode;
   assign modeClass = (mode[3:2] == 2'b11) ? ccpc_pkg::CLS_PWM : // R5
      (mode == ccpc_pkg::MODE_OFF) ? ccpc_pkg::CLS_OFF :
      (mode[3:2] == 2'b01) ? ccpc_pkg::CLS_CAPTURE :
      (mode == ccpc_pkg::MODE_TOGGLE || mode[3]) ? ccpc_pkg::CLS_COMPARE :
      ccpc_pkg::CLS_RESERVED; // R20
   wire logic isPwm = (modeClass == ccpc_pkg::CLS_PWM);
   wire logic isCompare = (modeClass == ccpc_pkg::CLS_COMPARE);
   wire logic isCapture = (modeClass == ccpc_pkg::CLS_CAPTURE);
   wire logic isOff = (modeClass == ccpc_pkg::CLS_OFF);

   // Unit 2 field; the other fields are stored for software only
   wire logic [1:0] srcField = timerSource[ccpc_pkg::UNIT2_SRC_LSB +: 2]; // R14
   wire logic [15:0] selTimer = srcField[0] ? timer3Count : timer1Count; // R15
   wire logic selPin = relocate ? pinIn[1] : pinIn[0]; // R16

   // ----------------------------------------
   // Capture
   // ----------------------------------------
   wire logic riseSeen = selPin && !inPrev;
   wire logic fallSeen = !selPin && inPrev;
   wire logic edgeSeen = isCapture &&
      ((mode == ccpc_pkg::MODE_CAP_FALL) ? fallSeen : riseSeen); // R8
   wire logic [3:0] lastCount = (mode == ccpc_pkg::MODE_CAP_RISE4) ?
      ccpc_pkg::PRESCALE_LAST_4 : (mode == ccpc_pkg::MODE_CAP_RISE16) ?
      ccpc_pkg::PRESCALE_LAST_16 : ccpc_pkg::PRESCALE_LAST_1; // R9
   wire logic captureFire;
   // Prescaler restarts whenever the unit leaves capture, so a mode
   // change never inherits a stale partial count
   wire logic prescaleClear = !isCapture || wrCtrl;

   ccpc_edge_prescale edgePrescale (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clear(prescaleClear),
      .edgeSeen(edgeSeen),
      .lastCount(lastCount),
      .fire(captureFire)
   );

   // ----------------------------------------
   // Compare
   // ----------------------------------------
   wire logic timerEqual = (selTimer == compareValue);
   // One hit per match, even while the timer rests on the value
   wire logic cmpHit = isCompare && timerEqual && !matchPrev;
   wire logic specialHit = cmpHit && (mode == ccpc_pkg::MODE_CMP_SPECIAL); // R13
   wire logic matchSet = captureFire || (cmpHit && !specialHit); // R10 R11 R12

   // ----------------------------------------
   // PWM time base
   // ----------------------------------------
   wire logic [3:0] tickSel = {1'b0, periodTick};
   // Reserved source never ticks, so the period stays frozen
   wire logic pwmTick = isPwm && (srcField != ccpc_pkg::SRC_RESERVED) &&
      tickSel[srcField]; // R19 R1
   wire logic periodEnd = (periodCount == periodLimit) &&
      (phase == ccpc_pkg::PWM_PHASE_LAST);
   wire logic pwmWrap = pwmTick && periodEnd; // R17
   wire logic [9:0] dutyValue = {dutyHigh, unitControl.dutyLow}; // R4
   wire logic [9:0] dutyLatched = {dutyShadow, dutyLatch};
   wire logic [9:0] timeBase = {periodCount, phase};
   wire logic [9:0] timeStep = timeBase + 10'h001;
   // Look at the step being taken, so the registered pin falls on the
   // tick at which the time base reaches the duty value, not one later
   wire logic dutyReached = pwmTick && (timeStep == dutyLatched); // R18
   wire logic [7:0] countStep = periodCount + 8'h01;
   wire logic [1:0] phaseStep = phase + 2'h1;

   // ----------------------------------------
   // Output level
   // ----------------------------------------
   always_comb begin
      next_level = outLevel;
      unique case (modeClass)
         ccpc_pkg::CLS_OFF: begin
            next_level = 1'b0; // R6
         end
         ccpc_pkg::CLS_COMPARE: begin
            if (cmpHit) begin
               if (mode == ccpc_pkg::MODE_TOGGLE) begin
                  next_level = !outLevel; // R7
               end else if (mode == ccpc_pkg::MODE_CMP_SET) begin
                  next_level = 1'b1; // R10
               end else if (mode == ccpc_pkg::MODE_CMP_CLR) begin
                  next_level = 1'b0; // R11
               end
            end
         end
         ccpc_pkg::CLS_PWM: begin
            if (pwmWrap) begin
               next_level = (dutyValue != 10'h000); // R17
            end else if (dutyReached) begin
               next_level = 1'b0; // R18
            end
         end
         ccpc_pkg::CLS_CAPTURE, ccpc_pkg::CLS_RESERVED: begin
            next_level = outLevel; // R20
         end
      endcase
   end

   wire logic drivePin = isCompare || isPwm;
   wire logic [1:0] next_pinOut = relocate ? {next_level, 1'b0} : {1'b0, next_level}; // R16
   wire logic [1:0] next_pinOe = relocate ? {drivePin, 1'b0} : {1'b0, drivePin};

   // ----------------------------------------
   // Read mux
   // ----------------------------------------
   wire logic [31:0] readMux =
      (avs_address == ccpc_pkg::ADDR_UNIT_CONTROL) ? {24'h0, 2'b00, unitControl[5:0]} : // R3
      (avs_address == ccpc_pkg::ADDR_TIMER_SOURCE) ? {24'h0, timerSource} :
      (avs_address == ccpc_pkg::ADDR_DUTY_HIGH) ? {24'h0, dutyHigh} :
      (avs_address == ccpc_pkg::ADDR_DUTY_SHADOW) ? {24'h0, dutyShadow} :
      (avs_address == ccpc_pkg::ADDR_CAPTURE) ? {16'h0, captureValue} :
      (avs_address == ccpc_pkg::ADDR_COMPARE) ? {16'h0, compareValue} :
      (avs_address == ccpc_pkg::ADDR_RELOCATE) ? {31'h0, relocate} :
      (avs_address == ccpc_pkg::ADDR_FLAGS) ? {30'h0, unit10EventFlag, matchEventFlag} :
      (avs_address == ccpc_pkg::ADDR_PERIOD) ? {24'h0, periodLimit} : 32'h0;

   // Set beats clear: an event in the clearing cycle survives
   wire logic next_match = (matchEventFlag &&
      !(wrFlags && avs_writedata[ccpc_pkg::FLAG_MATCH_BIT])) || matchSet;
   wire logic next_unit10 = (unit10EventFlag &&
      !(wrFlags && avs_writedata[ccpc_pkg::FLAG_UNIT10_BIT])) || specialHit;

   // ----------------------------------------
   // Bus slave registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         // One wait cycle per access, then low for exactly one cycle
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (rdStart) begin
            avs_readdata <= readMux;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         unitControl <= ccpc_pkg::UNIT_CONTROL_RST; // R2
         timerSource <= ccpc_pkg::TIMER_SOURCE_RST;
         dutyHigh <= ccpc_pkg::DUTY_RST;
         compareValue <= ccpc_pkg::WORD_RST;
         relocate <= 1'b0;
         periodLimit <= ccpc_pkg::PERIOD_RST;
      end else begin
         if (wrCtrl) begin
            unitControl <= {2'b00, avs_writedata[5:0]}; // R3
         end
         if (wrSrc) begin
            timerSource <= avs_writedata[7:0];
         end
         if (wrDuty) begin
            dutyHigh <= avs_writedata[7:0];
         end
         if (wrCmp) begin
            compareValue <= avs_writedata[15:0];
         end
         if (wrReloc) begin
            relocate <= avs_writedata[ccpc_pkg::RELOCATE_BIT];
         end
         if (wrPeriod) begin
            periodLimit <= avs_writedata[7:0];
         end
      end
   end

   // ----------------------------------------
   // Unit state
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         periodCount <= 8'h00;
         phase <= 2'h0;
         dutyShadow <= ccpc_pkg::DUTY_RST;
         dutyLatch <= 2'h0;
      end else if (!isPwm) begin
         periodCount <= 8'h00; // R6
         phase <= 2'h0;
         dutyShadow <= isOff ? ccpc_pkg::DUTY_RST : dutyShadow;
         dutyLatch <= isOff ? 2'h0 : dutyLatch;
      end else if (pwmWrap) begin
         periodCount <= 8'h00; // R17
         phase <= 2'h0;
         dutyShadow <= dutyHigh;
         dutyLatch <= unitControl.dutyLow;
      end else if (pwmTick) begin
         phase <= phaseStep;
         periodCount <= (phase == ccpc_pkg::PWM_PHASE_LAST) ? countStep : periodCount;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         captureValue <= ccpc_pkg::WORD_RST;
         outLevel <= 1'b0;
         inPrev <= 1'b0;
         matchPrev <= 1'b0;
         matchEventFlag <= 1'b0;
         unit10EventFlag <= 1'b0;
         adcStart <= 1'b0;
         pinOut <= 2'b00;
         pinOe <= 2'b00; // R2
      end else begin
         if (captureFire) begin
            captureValue <= selTimer; // R8
         end
         outLevel <= next_level;
         inPrev <= selPin;
         matchPrev <= timerEqual;
         matchEventFlag <= next_match;
         unit10EventFlag <= next_unit10;
         adcStart <= specialHit && adcEnable; // R13
         pinOut <= next_pinOut;
         pinOe <= next_pinOe;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   chk_ctrl_upper_zero: assert property (rdStart && avs_address == ccpc_pkg::ADDR_UNIT_CONTROL
      |=> !avs_waitrequest && avs_readdata[7:6] == 2'b00) // R3
      else $error("Control read showed upper bits or no answer");
   chk_off_pin_idle: assert property (isOff |=> pinOut == 2'b00 && pinOe == 2'b00) // R6
      else $error("Unit off but pin still driven");
   chk_toggle_invert: assert property (cmpHit && mode == ccpc_pkg::MODE_TOGGLE && !relocate
      |=> pinOut[0] != $past(pinOut[0])) // R7
      else $error("Toggle match did not invert pin");
   chk_capture_loads: assert property (captureFire |=> captureValue == $past(selTimer)) // R8
      else $error("Capture did not store timer");
   chk_set_high: assert property (cmpHit && mode == ccpc_pkg::MODE_CMP_SET && !relocate
      |=> pinOut[0] && matchEventFlag) // R10
      else $error("Set match failed");
   chk_clear_low: assert property (cmpHit && mode == ccpc_pkg::MODE_CMP_CLR && !relocate
      |=> !pinOut[0] && matchEventFlag) // R11
      else $error("Clear match failed");
   chk_soft_only: assert property (cmpHit && mode == ccpc_pkg::MODE_CMP_SOFT && !isOff
      |=> $stable(outLevel) && matchEventFlag) // R12
      else $error("Software match touched the pin");
   chk_special_event: assert property (specialHit
      |=> unit10EventFlag && adcStart == $past(adcEnable) ##1 !adcStart) // R13
      else $error("Special event trigger wrong");
   chk_wrap_latch: assert property (pwmWrap
      |=> dutyShadow == $past(dutyHigh) && periodCount == 8'h00 && phase == 2'h0) // R17
      else $error("Period end did not latch duty");
   chk_duty_low: assert property (isPwm && !pwmWrap && dutyReached && !relocate
      |=> !pinOut[0]) // R18
      else $error("Duty match left pin high");
   chk_reserved_keep: assert property (modeClass == ccpc_pkg::CLS_RESERVED && !wrFlags
      |=> $stable(matchEventFlag) && $stable(outLevel)) // R20
      else $error("Reserved mode changed state");

   cov_capture: cover property (captureFire && mode == ccpc_pkg::MODE_CAP_RISE16);
   cov_pwm_wrap: cover property (pwmWrap ##[1:1000] (isPwm && dutyReached));
   cov_special: cover property (specialHit && adcEnable);
   cov_toggle: cover property (cmpHit && mode == ccpc_pkg::MODE_TOGGLE);
endmodule : ccpc_unit

// ===== test/ccpc_pin_model.sv
// Far-side pin model for the capture/compare/PWM unit
`timescale 1ns/100ps
module ccpc_pin_model (
   // Unit side
   input wire logic [1:0] pinOut,
   input wire logic [1:0] pinOe,
   // Outside world
   input wire logic [1:0] extLevel,
   // Resolved wire
   output logic [1:0] pinIn
);
   // Driven pins read their own level, released ones follow the outside
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : ccpc_pin_model

// ===== test/test_capture_compare_pwm_control.sv
// Self-checking bench for the capture/compare/PWM unit
`timescale 1ns/100ps
module test_capture_compare_pwm_control;
   logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [15:0] timer1Count, timer3Count, cmpVal, tv, last;
   logic [2:0] periodTick;
   logic adcEnable, adcStart, matchEventFlag, unit10EventFlag;
   logic [1:0] pinIn, pinOut, pinOe, extLevel;
   logic [3:0] modes [6] = '{4'h8, 4'h9, 4'h2, 4'hA, 4'hB, 4'h1};
   logic [2:0] expCmp [6] = '{3'h6, 3'h2, 3'h6, 3'h6, 3'h5, 3'h4};
   logic [31:0] expQ [$];
   int n_fail, checks, cycles, adcPulses, highCount, h1, h2, n;

   ccpc_unit dut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .timer1Count, .timer3Count,
      .periodTick, .adcEnable, .adcStart, .matchEventFlag, .unit10EventFlag,
      .pinIn, .pinOut, .pinOe);
   ccpc_pin_model farSide (.pinOut, .pinOe, .extLevel, .pinIn);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic cmp(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp

   // Called right after a rising edge; holds the request until waitrequest is low
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      // Only the bench timeout ends a wait that never gets an answer
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic hit(input logic sel, input logic [15:0] v);
      if (sel) timer3Count <= v;
      else timer1Count <= v;
      repeat (3) @(posedge ref_clk);
      timer1Count <= ~v;
      timer3Count <= ~v;
      @(posedge ref_clk);
   endtask : hit

   // Unit 2 source is 01 here, so capture follows the third timer only
   task automatic pulse(input logic [15:0] v);
      timer3Count <= v;
      timer1Count <= ~v;
      extLevel <= 2'h1;
      repeat (3) @(posedge ref_clk);
      timer3Count <= ~v;
      timer1Count <= v;
      extLevel <= 2'h0;
      repeat (3) @(posedge ref_clk);
   endtask : pulse

   // Other period ticks are random so a wrong source choice shows up
   task automatic pwm(output int h);
      int h0;
      h0 = 0;
      for (int i = 0; i < 156; i++) begin
         if (i == 36) h0 = highCount;
         periodTick <= {1'($urandom), 1'b1, 1'($urandom)};
         @(posedge ref_clk);
      end
      h = highCount - h0;
   endtask : pwm

   // ----------------------------------------
   // Result watcher and timeout
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      adcPulses <= adcPulses + int'(adcStart === 1'b1);
      highCount <= highCount + int'(pinOut[0] === 1'b1);
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp(expQ.pop_front(), avs_readdata);
      if (cycles > 8000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      {avs_read, avs_write, adcEnable, reset_n} = 4'h0;
      {avs_address, avs_writedata, periodTick, extLevel} = '0;
      {timer1Count, timer3Count} = 32'h0;
      {n_fail, checks, cycles, adcPulses, highCount} = '0;
      n = $urandom(29);
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      cmp(32'h0, {pinOe, pinOut, matchEventFlag, unit10EventFlag, adcStart});
      rd(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h0);
      rd(ccpc_pkg::ADDR_PERIOD, {24'h0, ccpc_pkg::PERIOD_RST});
      rd(6'h3C, 32'h0);
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, 32'hFF);
      rd(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h3F);
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h0);
      // Pins settle one edge after the mode write lands
      @(posedge ref_clk);
      cmp(32'h0, {pinOe, pinOut});
      tv = 16'($urandom);
      wr(ccpc_pkg::ADDR_TIMER_SOURCE, {24'h0, tv[7:0]});
      rd(ccpc_pkg::ADDR_TIMER_SOURCE, {24'h0, tv[7:0]});
      wr(ccpc_pkg::ADDR_TIMER_SOURCE, 32'h0);
      // ----------------------------------------
      // Compare modes and reserved mode 0001, one match each
      // ----------------------------------------
      cmpVal = 16'($urandom);
      timer1Count <= ~cmpVal;
      timer3Count <= ~cmpVal;
      adcEnable <= 1'b1;
      wr(ccpc_pkg::ADDR_COMPARE, {16'h0, cmpVal});
      for (int i = 0; i < 6; i++) begin
         wr(ccpc_pkg::ADDR_UNIT_CONTROL, {28'h0, modes[i]});
         hit(1'b0, cmpVal);
         cmp({29'h0, expCmp[i]}, {pinOut[0], matchEventFlag, unit10EventFlag});
         wr(ccpc_pkg::ADDR_FLAGS, 32'h3);
      end
      cmp(32'h1, adcPulses);
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h0);
      @(posedge ref_clk);
      cmp(32'h0, {pinOe, pinOut});
      wr(ccpc_pkg::ADDR_TIMER_SOURCE, 32'h4);
      wr(ccpc_pkg::ADDR_RELOCATE, 32'h1);
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, {28'h0, ccpc_pkg::MODE_CMP_SET});
      hit(1'b0, cmpVal);
      cmp(32'h0, {pinOut, matchEventFlag});
      hit(1'b1, cmpVal);
      cmp(32'hA, {pinOe, pinOut});
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h0);
      wr(ccpc_pkg::ADDR_RELOCATE, 32'h0);
      // ----------------------------------------
      // Capture on edges and prescaled edges
      // ----------------------------------------
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, {28'h0, ccpc_pkg::MODE_CAP_RISE});
      tv = 16'($urandom);
      pulse(tv);
      rd(ccpc_pkg::ADDR_CAPTURE, {16'h0, tv});
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, {28'h0, ccpc_pkg::MODE_CAP_FALL});
      pulse(tv);
      rd(ccpc_pkg::ADDR_CAPTURE, {16'h0, ~tv});
      last = ~tv;
      for (int m = 0; m < 2; m++) begin
         n = m ? 16 : 4;
         wr(ccpc_pkg::ADDR_UNIT_CONTROL, {28'h0, m ? 4'h7 : 4'h6});
         for (int k = 1; k <= n; k++) begin
            tv = 16'($urandom);
            pulse(tv);
            rd(ccpc_pkg::ADDR_CAPTURE, {16'h0, k == n ? tv : last});
         end
         last = tv;
      end
      // ----------------------------------------
      // PWM through period timer 1
      // ----------------------------------------
      wr(ccpc_pkg::ADDR_PERIOD, 32'h2);
      wr(ccpc_pkg::ADDR_DUTY_HIGH, 32'h1);
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h2C);
      pwm(h1);
      wr(ccpc_pkg::ADDR_DUTY_HIGH, 32'h2);
      pwm(h2);
      cmp(32'd40, h2 - h1);
      cmp(32'd60, h1);
      rd(ccpc_pkg::ADDR_DUTY_SHADOW, 32'h2);
      wr(ccpc_pkg::ADDR_DUTY_HIGH, 32'h0);
      wr(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h0C);
      pwm(h1);
      cmp(32'h0, h1);
      // Reset in mid-run must bring registers and pins back
      reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      cmp(32'h0, {pinOe, pinOut});
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(ccpc_pkg::ADDR_UNIT_CONTROL, 32'h0);
      rd(ccpc_pkg::ADDR_TIMER_SOURCE, 32'h0);
      stop_test();
   end
endmodule : test_capture_compare_pwm_control
